// ---- core/rcvcfg_consts.svh ----
`ifndef RCVCFG_CONSTS_SVH
`define RCVCFG_CONSTS_SVH

`define RCVCFG_ADDR_THRESHOLD 8'h37
`define RCVCFG_ADDR_CONTROL 8'h38
`define RCVCFG_ADDR_ANALOG 8'h39

`define RCVCFG_THRESHOLD_RESET 8'h00
`define RCVCFG_CONTROL_RESET 8'h00
`define RCVCFG_ANALOG_RESET 8'h00

`define RCVCFG_THRESHOLD_MASK 8'hff
`define RCVCFG_CONTROL_MASK 8'hf3
`define RCVCFG_ANALOG_MASK 8'hcf

`define RCVCFG_DEC_MIN_MSB 7
`define RCVCFG_DEC_MIN_LSB 4
`define RCVCFG_PHS_MIN_MSB 3
`define RCVCFG_PHS_MIN_LSB 0
`define RCVCFG_PIN_MODE_BIT 7
`define RCVCFG_CONV_MODE_BIT 6
`define RCVCFG_SRC_MSB 5
`define RCVCFG_SRC_LSB 4
`define RCVCFG_COLL_MSB 1
`define RCVCFG_COLL_LSB 0
`define RCVCFG_TRIM_MSB 7
`define RCVCFG_TRIM_LSB 6
`define RCVCFG_HPCF_MSB 3
`define RCVCFG_HPCF_LSB 2
`define RCVCFG_GAIN_MSB 1
`define RCVCFG_GAIN_LSB 0

`endif

// ---- core/rcvcfg_pkg.sv ----
package rcvcfg_pkg;

    typedef enum logic [1:0] {
        RCVCFG_SRC_IDLE = 2'b00,
        RCVCFG_SRC_ANALOG = 2'b01,
        RCVCFG_SRC_ENVELOPE = 2'b10,
        RCVCFG_SRC_GENERIC = 2'b11
    } rcvcfg_source_type;

    typedef enum logic [1:0] {
        RCVCFG_COLL_EIGHTH = 2'b00,
        RCVCFG_COLL_QUARTER = 2'b01,
        RCVCFG_COLL_HALF = 2'b10,
        RCVCFG_COLL_OFF = 2'b11
    } rcvcfg_collision_type;

    // register-port request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } rcvcfg_req_type;

    // settings driven into the receive path
    typedef struct packed {
        logic [3:0] decoder_min_level;
        logic [3:0] phase_detector_min_level;
        logic quasi_differential;
        logic low_power_card_detect;
        rcvcfg_source_type processing_source_select;
        rcvcfg_collision_type collision_strength_threshold;
        logic collision_detect_enable;
        logic [1:0] midpoint_trim;
        logic [1:0] hpcf_select;
        logic [1:0] gain_select;
    } rcvcfg_settings_type;

endpackage

// ---- core/rcvcfg_regs.sv ----
`timescale 1ns/1ps
`include "rcvcfg_consts.svh"

module rcvcfg_regs
    import rcvcfg_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input rcvcfg_req_type req,
    output logic [7:0] rdata_ff,
    output logic rvalid_ff,
    output rcvcfg_settings_type settings_ff
);

    logic [7:0] threshold_ff;
    logic [7:0] control_ff;
    logic [7:0] analog_ff;
    logic [7:0] nxt_rdata;
    rcvcfg_settings_type nxt_settings;

    logic wr_thr;
    logic wr_ctl;
    logic wr_ana;

    assign wr_thr = req.wr && (req.addr == `RCVCFG_ADDR_THRESHOLD);
    assign wr_ctl = req.wr && (req.addr == `RCVCFG_ADDR_CONTROL);
    assign wr_ana = req.wr && (req.addr == `RCVCFG_ADDR_ANALOG);

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            threshold_ff <= `RCVCFG_THRESHOLD_RESET;
        end else if (wr_thr) begin
            threshold_ff <= req.wdata & `RCVCFG_THRESHOLD_MASK;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            control_ff <= `RCVCFG_CONTROL_RESET;
        end else if (wr_ctl) begin
            control_ff <= req.wdata & `RCVCFG_CONTROL_MASK;
        end
    end

    // reserved bits 5:4 masked; trim stored as written
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            analog_ff <= `RCVCFG_ANALOG_RESET;
        end else if (wr_ana) begin
            analog_ff <= req.wdata & `RCVCFG_ANALOG_MASK;
        end
    end

    // unmapped addresses read as zero
    always_comb begin
        unique case (req.addr)
            `RCVCFG_ADDR_THRESHOLD: nxt_rdata = threshold_ff;
            `RCVCFG_ADDR_CONTROL: nxt_rdata = control_ff;
            `RCVCFG_ADDR_ANALOG: nxt_rdata = analog_ff;
            default: nxt_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rdata_ff <= 8'h00;
            rvalid_ff <= 1'b0;
        end else begin
            rvalid_ff <= req.rd;
            // read takes the old word, so wr with rd returns pre-write value
            if (req.rd) begin
                rdata_ff <= nxt_rdata;
            end
        end
    end

    // settings follow the registers one cycle later, from a flop
    always_comb begin
        nxt_settings.decoder_min_level =
            threshold_ff[`RCVCFG_DEC_MIN_MSB:`RCVCFG_DEC_MIN_LSB];
        nxt_settings.phase_detector_min_level =
            threshold_ff[`RCVCFG_PHS_MIN_MSB:`RCVCFG_PHS_MIN_LSB];
        nxt_settings.quasi_differential = control_ff[`RCVCFG_PIN_MODE_BIT];
        nxt_settings.low_power_card_detect = control_ff[`RCVCFG_CONV_MODE_BIT];
        nxt_settings.processing_source_select =
            rcvcfg_source_type'(control_ff[`RCVCFG_SRC_MSB:`RCVCFG_SRC_LSB]);
        // collision level, code 3 switches detection off
        nxt_settings.collision_strength_threshold =
            rcvcfg_collision_type'(control_ff[`RCVCFG_COLL_MSB:`RCVCFG_COLL_LSB]);
        nxt_settings.collision_detect_enable =
            control_ff[`RCVCFG_COLL_MSB:`RCVCFG_COLL_LSB] != RCVCFG_COLL_OFF;
        // passed through; only zero is meaningful
        nxt_settings.midpoint_trim = analog_ff[`RCVCFG_TRIM_MSB:`RCVCFG_TRIM_LSB];
        nxt_settings.hpcf_select = analog_ff[`RCVCFG_HPCF_MSB:`RCVCFG_HPCF_LSB];
        nxt_settings.gain_select = analog_ff[`RCVCFG_GAIN_MSB:`RCVCFG_GAIN_LSB];
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            settings_ff <= '0;
        end else begin
            settings_ff <= nxt_settings;
        end
    end

    // assertions
    sequence s_thr_write;
        req.wr && req.addr == `RCVCFG_ADDR_THRESHOLD;
    endsequence

    sequence s_ctl_write;
        req.wr && req.addr == `RCVCFG_ADDR_CONTROL;
    endsequence

    sequence s_ana_write;
        req.wr && req.addr == `RCVCFG_ADDR_ANALOG;
    endsequence

    sequence s_thr_read;
        req.rd && req.addr == `RCVCFG_ADDR_THRESHOLD;
    endsequence

    sequence s_ctl_read;
        req.rd && req.addr == `RCVCFG_ADDR_CONTROL;
    endsequence

    sequence s_ana_read;
        req.rd && req.addr == `RCVCFG_ADDR_ANALOG;
    endsequence

    // gap with no write, so the later read still sees the earlier write
    sequence s_no_write;
        !req.wr;
    endsequence

    AST_DEC_LEVEL: assert property (@(posedge clock) disable iff (!rst_n)
        s_thr_write |-> ##2 settings_ff.decoder_min_level == $past(req.wdata[7:4], 2))
        else $error("decoder level not taken");

    AST_PHS_LEVEL: assert property (@(posedge clock) disable iff (!rst_n)
        s_thr_write |-> ##2 settings_ff.phase_detector_min_level == $past(req.wdata[3:0], 2))
        else $error("phase level not taken");

    AST_PIN_MODE: assert property (@(posedge clock) disable iff (!rst_n)
        s_ctl_write |-> ##2 settings_ff.quasi_differential == $past(req.wdata[7], 2))
        else $error("pin mode wrong");

    AST_CONV_MODE: assert property (@(posedge clock) disable iff (!rst_n)
        s_ctl_write |-> ##2 settings_ff.low_power_card_detect == $past(req.wdata[6], 2))
        else $error("converter mode wrong");

    AST_SOURCE: assert property (@(posedge clock) disable iff (!rst_n)
        s_ctl_write |-> ##2 settings_ff.processing_source_select == $past(req.wdata[5:4], 2))
        else $error("source select wrong");

    AST_COLL_OFF: assert property (@(posedge clock) disable iff (!rst_n)
        s_ctl_write
        |-> ##2 settings_ff.collision_detect_enable == ($past(req.wdata[1:0], 2) != 2'b11))
        else $error("collision enable mismatch");

    AST_COLL_LEVEL: assert property (@(posedge clock) disable iff (!rst_n)
        s_ctl_write
        |-> ##2 settings_ff.collision_strength_threshold == $past(req.wdata[1:0], 2))
        else $error("collision level wrong");

    AST_HPCF: assert property (@(posedge clock) disable iff (!rst_n)
        s_ana_write |-> ##2 settings_ff.hpcf_select == $past(req.wdata[3:2], 2))
        else $error("corner select wrong");

    AST_GAIN: assert property (@(posedge clock) disable iff (!rst_n)
        s_ana_write |-> ##2 settings_ff.gain_select == $past(req.wdata[1:0], 2))
        else $error("gain select wrong");

    // reserved control bits come back as zero whatever was written
    AST_RSV_ZERO: assert property (@(posedge clock) disable iff (!rst_n)
        s_ctl_read |=> rvalid_ff && rdata_ff[3:2] == 2'b00)
        else $error("reserved bits not zero");

    AST_ANA_RSV_ZERO: assert property (@(posedge clock) disable iff (!rst_n)
        s_ana_read |=> rvalid_ff && rdata_ff[5:4] == 2'b00)
        else $error("analog reserved bits not zero");

    // write, quiet cycle, read: the read returns the masked write
    AST_THR_READBACK: assert property (@(posedge clock) disable iff (!rst_n)
        s_thr_write ##1 s_no_write ##1 s_thr_read |=> rdata_ff == $past(req.wdata, 3))
        else $error("threshold read back wrong");

    AST_CTL_READBACK: assert property (@(posedge clock) disable iff (!rst_n)
        s_ctl_write ##1 s_no_write ##1 s_ctl_read
        |=> rdata_ff == ($past(req.wdata, 3) & `RCVCFG_CONTROL_MASK))
        else $error("control read back wrong");

    AST_ANA_READBACK: assert property (@(posedge clock) disable iff (!rst_n)
        s_ana_write ##1 s_no_write ##1 s_ana_read
        |=> rdata_ff == ($past(req.wdata, 3) & `RCVCFG_ANALOG_MASK))
        else $error("analog read back wrong");

    AST_RD_VALID: assert property (@(posedge clock) disable iff (!rst_n)
        req.rd |=> rvalid_ff)
        else $error("read not answered");

    AST_NO_STRAY: assert property (@(posedge clock) disable iff (!rst_n)
        !req.rd |=> !rvalid_ff)
        else $error("stray read valid");

    AST_UNMAPPED_RD: assert property (@(posedge clock) disable iff (!rst_n)
        req.rd && (req.addr < `RCVCFG_ADDR_THRESHOLD || req.addr > `RCVCFG_ADDR_ANALOG)
        |=> rdata_ff == 8'h00)
        else $error("unmapped read not zero");

endmodule

// ---- testbench/rcvcfg_regs_tb_top.sv ----
`timescale 1ns/1ps
`include "rcvcfg_consts.svh"
module rcvcfg_regs_tb_top;
    import rcvcfg_pkg::*;
    logic clock;
    logic rst_n;
    rcvcfg_req_type req;
    logic [7:0] rdata_ff;
    logic rvalid_ff;
    rcvcfg_settings_type settings_ff;
    logic [7:0] shadow [3];
    logic [7:0] exp_q [$];
    logic [31:0] seed;
    logic [7:0] a;
    logic [7:0] d;
    int bad_count;
    int checks;

    rcvcfg_regs dut_u (.clock(clock), .rst_n(rst_n), .req(req), .rdata_ff(rdata_ff),
        .rvalid_ff(rvalid_ff), .settings_ff(settings_ff));

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    function automatic logic [31:0] xorshift();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic [7:0] wmask(input logic [7:0] addr);
        case (addr)
            `RCVCFG_ADDR_THRESHOLD: return `RCVCFG_THRESHOLD_MASK;
            `RCVCFG_ADDR_CONTROL: return `RCVCFG_CONTROL_MASK;
            default: return `RCVCFG_ANALOG_MASK;
        endcase
    endfunction

    // collision enable is off only for code 3
    function automatic logic [20:0] exp_set();
        return {shadow[0], shadow[1][7:4], shadow[1][1:0], shadow[1][1:0] != 2'b11,
            shadow[2][7:6], shadow[2][3:2], shadow[2][1:0]};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] expv);
        checks++;
        if (seen !== expv) begin
            bad_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, expv);
        end
    endtask

    task automatic finish_test();
        if (bad_count == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // read note is taken before the write lands: wr+rd shows old value
    task automatic bus(input logic wr, input logic rd, input logic [7:0] addr,
        input logic [7:0] data);
        req <= '{wr: wr, rd: rd, addr: addr, wdata: data};
        if (rd) exp_q.push_back((addr >= 8'h37 && addr <= 8'h39) ? shadow[addr - 8'h37] : 8'h00);
        if (wr && addr >= 8'h37 && addr <= 8'h39) shadow[addr - 8'h37] = data & wmask(addr);
        @(negedge clock);
    endtask

    task automatic idle();
        req <= '0;
        @(negedge clock);
    endtask

    task automatic do_reset();
        rst_n <= 1'b0;
        repeat (8) @(posedge clock);
        @(negedge clock);
        rst_n <= 1'b1;
        shadow = '{`RCVCFG_THRESHOLD_RESET, `RCVCFG_CONTROL_RESET, `RCVCFG_ANALOG_RESET};
        @(negedge clock);
        check(32'(settings_ff), 32'(exp_set()));
        for (int i = 0; i < 4; i++) bus(1'b0, 1'b1, 8'h37 + 8'(i), 8'h00);
        idle();
    endtask

    // one note per read strobe; stray rvalid finds an empty queue
    always @(posedge clock) begin
        #1;
        if (rvalid_ff === 1'b1) begin
            if (exp_q.size() == 0) check(1, 0);
            else check(32'(rdata_ff), 32'(exp_q.pop_front()));
        end
    end

    initial begin
        #200000;
        bad_count++;
        finish_test();
    end

    initial begin
        req = '0;
        rst_n = 1'b0;
        seed = 32'h0000_ec2e;
        do_reset();
        repeat (24) begin
            a = 8'h37 + 8'(xorshift() % 3);
            d = 8'(xorshift());
            if (a == `RCVCFG_ADDR_THRESHOLD && d[7:4] == 4'h0) d[7:4] = 4'h1;
            if (a == `RCVCFG_ADDR_ANALOG) d[7:6] = 2'b00;
            bus(1'b1, 1'b0, a, d);
            idle();
            check(32'(settings_ff), 32'(exp_set()));
            bus(1'b0, 1'b1, a, 8'h00);
        end
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, 1'b0, `RCVCFG_ADDR_CONTROL, {i[1:0], i[1:0], 2'b11, i[1:0]});
            idle();
            check(32'(settings_ff), 32'(exp_set()));
            bus(1'b0, 1'b1, `RCVCFG_ADDR_CONTROL, 8'h00);
        end
        // unmapped places and wr with rd
        bus(1'b1, 1'b0, 8'h36, 8'hff);
        bus(1'b1, 1'b0, 8'h3a, 8'hff);
        bus(1'b0, 1'b1, 8'h36, 8'h00);
        bus(1'b1, 1'b1, `RCVCFG_ADDR_ANALOG, 8'h3f);
        bus(1'b0, 1'b1, `RCVCFG_ADDR_ANALOG, 8'h00);
        idle();
        check(32'(settings_ff), 32'(exp_set()));
        do_reset();
        repeat (3) idle();
        check(exp_q.size(), 0);
        finish_test();
    end
endmodule
